// ==== logic/smtp_debounce.sv ====
`timescale 1ns/100ps
`default_nettype none
module smtp_debounce (
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst,
    // strobe path
    smtp_strobe_if.filt    sif
);
    typedef struct packed {
        logic                          stable;
        logic [smtp_pkg::DB_CNT_W-1:0] cnt;
        logic                          rise;
    } smtp_db_t;

    smtp_db_t st_reg;
    smtp_db_t st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.rise = 1'b0;
        if (sif.raw == st_reg.stable) begin
            st_next.cnt = '0;
        end else if (st_reg.cnt == smtp_pkg::DB_LEN - 8'h01) begin
            st_next.cnt    = '0;
            st_next.stable = sif.raw;
            st_next.rise   = sif.raw;
        end else begin
            st_next.cnt = st_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            // idle high, matching the recommended pull-up
            st_reg <= '{stable: 1'b1, cnt: '0, rise: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign sif.rise = st_reg.rise;
endmodule : smtp_debounce
`default_nettype wire

// ==== logic/smtp_pkg.sv ====
package smtp_pkg;
    localparam int        CODE_W          = 8;
    localparam int        CLK_MHZ         = 200;
    // strobe must hold steady this long before it is believed
    localparam int        DEBOUNCE_US     = 1;
    localparam int        DEBOUNCE_CYC    = DEBOUNCE_US * CLK_MHZ;
    localparam int        DB_CNT_W        = 8;
    // playback length per message stands in for the speech rom walk
    localparam int        PLAY_US         = 10;
    localparam int        PLAY_CYC        = PLAY_US * CLK_MHZ;
    localparam int        PLAY_CNT_W      = 12;
    localparam logic [7:0] CODE_RST       = 8'h00;
    localparam logic [11:0] PLAY_LEN      = 12'(PLAY_CYC);
    localparam logic [7:0]  DB_LEN        = 8'(DEBOUNCE_CYC);
endpackage : smtp_pkg

// ==== logic/smtp_strobe_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface smtp_strobe_if;
    logic raw;
    logic rise;
    modport filt (input raw, output rise);
    modport core (output raw, input rise);
endinterface : smtp_strobe_if
`default_nettype wire

// ==== logic/smtp_trigger_port.sv ====
`timescale 1ns/100ps
`default_nettype none
// Function
// - ignore strobe and select unless chip selected
// - accept 8-bit message code
// - latch code on strobe rise, start speaking
// - debounce the write strobe internally
// - return idle after message ends unaided
// - raise completion interrupt at message end
// - interrupt is driven high on completion
// - new write aborts current, starts new message
module smtp_trigger_port (
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       RST,
    // host pins
    input  wire logic       CHIP_SELECT_N,
    input  wire logic       WRITE_STROBE_N,
    input  wire logic [7:0] MESSAGE_SELECT_LINES,
    // status
    output logic            COMPLETION_INTERRUPT,
    output logic            SPEAKING,
    output logic [7:0]      MESSAGE_CODE,
    output logic            MESSAGE_START
);
    // playback states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h1,
        ST_SPEAK = 2'h2
    } smtp_state_t;

    // every flop of the port outside the debounce filter sits in this one record
    typedef struct packed {
        // pin synchronisers
        logic [1:0]                      cs_sync;
        logic [1:0]                      wr_sync;
        logic [smtp_pkg::CODE_W-1:0]     sel_meta;
        logic [smtp_pkg::CODE_W-1:0]     sel_hold;
        // message state
        smtp_state_t                     state;
        logic [smtp_pkg::CODE_W-1:0]     code;
        logic [smtp_pkg::PLAY_CNT_W-1:0] play_cnt;
        // status
        logic                            completion_interrupt;
        logic                            start;
    } smtp_core_t;

    // pins come out of reset as idle high so neither chip select nor strobe
    // shows a false edge in the first cycles after release
    localparam smtp_core_t CORE_RST = '{
        cs_sync:  2'h3,
        wr_sync:  2'h3,
        sel_meta: 8'h00,
        sel_hold: 8'h00,
        state:    ST_IDLE,
        code:     smtp_pkg::CODE_RST,
        play_cnt: 12'h000,
        completion_interrupt:     1'b0,
        start:    1'b0
    };

    // latency from a strobe rise on the pin to the start pulse:
    //   two flops of synchroniser, then the filter needs the high level steady
    //   for the full debounce count, then one flop for the start pulse.
    // the select lines pass the same two flops, so the host must keep the code
    // standing until the start pulse is out; a code that changes while the
    // filter counts is taken as it stands at the moment the filter fires.
    // a write that lands on the very cycle a message ends wins: the new message
    // starts and the interrupt for the old one never shows, which is what an
    // abort would have done a cycle earlier anyway.

    // one step of a two-flop pin synchroniser: the pin enters the first
    // stage, the first stage moves to the second; only the second is read
    function automatic logic [1:0] sync_step(input logic [1:0] stages, input logic pin);
        logic [1:0] moved;
        moved = {stages[0], pin};
        return moved;
    endfunction : sync_step

    // true on the last count of a message
    function automatic logic play_last(input logic [smtp_pkg::PLAY_CNT_W-1:0] cnt);
        logic hit;
        hit = (cnt == (smtp_pkg::PLAY_LEN - 12'h001));
        return hit;
    endfunction : play_last

    // decoded both for the status pin and for the end-of-message test
    function automatic logic is_speaking(input smtp_state_t s);
        logic busy;
        busy = (s == ST_SPEAK);
        return busy;
    endfunction : is_speaking

    smtp_core_t    st_reg;
    smtp_core_t    st_next;
    smtp_strobe_if sif ();

    logic                        cs_ok;
    logic                        accept;
    logic                        msg_done;
    logic [smtp_pkg::CODE_W-1:0] sel_now;
    logic [smtp_pkg::CODE_W-1:0] sel_meta_d;
    logic [smtp_pkg::CODE_W-1:0] sel_hold_d;

    // each select line has its own two-flop chain; bits need not settle in the
    // same cycle, which is why the code must stand before the strobe
    for (genvar i = 0; i < smtp_pkg::CODE_W; i++) begin : g_sel_sync
        assign sel_meta_d[i] = MESSAGE_SELECT_LINES[i];
        assign sel_hold_d[i] = st_reg.sel_meta[i];
    end

    assign cs_ok    = ~st_reg.cs_sync[1];
    assign sel_now  = st_reg.sel_hold;
    // deselect looks like idle-high, so the filter can never count a strobe
    // that arrived while the port was not selected
    assign sif.raw  = cs_ok ? st_reg.wr_sync[1] : 1'b1;
    assign accept   = sif.rise && cs_ok;
    assign msg_done = is_speaking(st_reg.state) && play_last(st_reg.play_cnt);

    smtp_debounce u_debounce (
        .clk (CLK),
        .rst (RST),
        .sif (sif)
    );

    always_comb begin
        st_next = st_reg;

        // pin synchronisers advance every cycle
        st_next.cs_sync  = sync_step(st_reg.cs_sync, CHIP_SELECT_N);
        st_next.wr_sync  = sync_step(st_reg.wr_sync, WRITE_STROBE_N);
        st_next.sel_meta = sel_meta_d;
        st_next.sel_hold = sel_hold_d;

        // start is a one-cycle pulse
        st_next.start = 1'b0;

        // a filtered rise wins over any playback in progress, also over its end
        if (accept) begin
            st_next.code     = sel_now;
            st_next.state    = ST_SPEAK;
            st_next.play_cnt = '0;
            st_next.completion_interrupt     = 1'b0;
            st_next.start    = 1'b1;
        end else begin
            unique case (st_reg.state)
                ST_IDLE: begin
                    st_next.play_cnt = '0;
                end
                ST_SPEAK: begin
                    if (msg_done) begin
                        st_next.state    = ST_IDLE;
                        st_next.play_cnt = '0;
                        st_next.completion_interrupt     = 1'b1;
                    end else begin
                        st_next.play_cnt = st_reg.play_cnt + 12'h001;
                    end
                end
                default: begin
                    // a broken one-hot code falls back to idle without an interrupt
                    st_next.state    = ST_IDLE;
                    st_next.play_cnt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_reg <= CORE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign COMPLETION_INTERRUPT = st_reg.completion_interrupt;
    assign SPEAKING             = is_speaking(st_reg.state);
    assign MESSAGE_CODE         = st_reg.code;
    assign MESSAGE_START        = st_reg.start;
endmodule : smtp_trigger_port
`default_nettype wire

// ==== test/smtp_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module smtp_host (
    // clock from the bench
    input  wire logic       clk,
    // host pins of the port
    output logic            cs_n,
    output logic            wr_n,
    output logic [7:0]      sel
);
    initial begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        sel = 8'h00;
    end
    // code is held well past the debounce window, then scrambled so a late sample shows
    task automatic send(input logic [7:0] c, input logic cs, input int low);
        @(posedge clk) #1 cs_n = cs;
        sel = c;
        @(posedge clk) #1 wr_n = 1'b0;
        repeat (low) @(posedge clk);
        #1 wr_n = 1'b1;
        repeat (210) @(posedge clk);
        #1 sel = ~c;
        cs_n = 1'b1;
    endtask : send
endmodule : smtp_host
`default_nettype wire

// ==== test/smtp_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module smtp_props (
    // clock, reset, pins
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic       CHIP_SELECT_N,
    input wire logic       WRITE_STROBE_N,
    input wire logic [7:0] MESSAGE_SELECT_LINES,
    // status
    input wire logic       COMPLETION_INTERRUPT,
    input wire logic       SPEAKING,
    input wire logic [7:0] MESSAGE_CODE,
    input wire logic       MESSAGE_START
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    logic [11:0] play_reg;
    always_ff @(posedge CLK) play_reg <= (RST || MESSAGE_START) ? 12'h000 : play_reg + 12'h001;
    a_cs_gates: assert property (MESSAGE_START |-> !$past(CHIP_SELECT_N, 5)) else $error("start unselected");
    a_strobe_high: assert property (MESSAGE_START |-> $past(WRITE_STROBE_N, 4)) else $error("strobe low");
    a_start_pulse: assert property (MESSAGE_START |=> !MESSAGE_START) else $error("long start");
    a_start_state: assert property (MESSAGE_START |-> SPEAKING && !COMPLETION_INTERRUPT) else $error("bad start");
    a_code_held: assert property (!MESSAGE_START |-> $stable(MESSAGE_CODE)) else $error("code moved");
    a_end_completion_interrupt: assert property ($fell(SPEAKING) |-> COMPLETION_INTERRUPT) else $error("no interrupt");
    a_completion_interrupt_clear: assert property ($fell(COMPLETION_INTERRUPT) |-> MESSAGE_START) else $error("completion_interrupt lost");
    // one cycle of slack either way around the last playback count, one less than the playback length
    a_play_len: assert property ($fell(SPEAKING) |-> play_reg inside {[12'h7ce:12'h7d0]}) else $error("length");
    c_abort: cover property (MESSAGE_START && $past(SPEAKING));
    c_end: cover property ($fell(SPEAKING));
    c_clear: cover property ($fell(COMPLETION_INTERRUPT));
endmodule : smtp_props
bind smtp_trigger_port smtp_props u_props (.CLK, .RST, .CHIP_SELECT_N, .WRITE_STROBE_N, .MESSAGE_SELECT_LINES,
    .COMPLETION_INTERRUPT, .SPEAKING, .MESSAGE_CODE, .MESSAGE_START);
`default_nettype wire

// ==== test/smtp_trigger_port_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t bad", $time); end end
module smtp_trigger_port_tb;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic cs_n, wr_n, completion_interrupt, spk, start;
    logic [7:0] sel, code;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'ha0ae3932;
    int num_errors = 0;
    int n_compared = 0;
    always #2.5 CLK = ~CLK;
    smtp_host u_host (.clk(CLK), .cs_n(cs_n), .wr_n(wr_n), .sel(sel));
    smtp_trigger_port u_dut (.CLK(CLK), .RST(RST), .CHIP_SELECT_N(cs_n), .WRITE_STROBE_N(wr_n),
        .MESSAGE_SELECT_LINES(sel), .COMPLETION_INTERRUPT(completion_interrupt), .SPEAKING(spk), .MESSAGE_CODE(code),
        .MESSAGE_START(start));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic tally_and_finish;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic go(input logic [7:0] c, input logic cs, input int low);
        if (!cs && low > smtp_pkg::DEBOUNCE_CYC) exp_q.push_back(c);
        u_host.send(c, cs, low);
    endtask : go
    task automatic wait_done;
        int n = 0;
        while (completion_interrupt !== 1'b1 && n < 3000) begin
            @(posedge CLK);
            #1;
            n++;
        end
        `CHK(completion_interrupt, 1'b1)
        `CHK(spk, 1'b0)
    endtask : wait_done
    always @(posedge CLK) begin
        #1;
        if (start === 1'b1) begin
            `CHK(exp_q.size() > 0, 1'b1)
            if (exp_q.size() > 0) `CHK(code, exp_q.pop_front())
            `CHK(completion_interrupt, 1'b0)
        end
    end
    initial begin
        repeat (10) @(posedge CLK);
        #1 RST = 1'b0;
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            go(seed[7:0], 1'b0, 220);
            wait_done();
        end
        go(8'h5a, 1'b1, 220);
        go(8'ha5, 1'b0, 50);
        `CHK(completion_interrupt, 1'b1)
        go(8'h00, 1'b0, 220);
        go(8'hff, 1'b0, 220);
        wait_done();
        `CHK(exp_q.size(), 0)
        tally_and_finish();
    end
    initial begin
        #150us;
        num_errors++;
        tally_and_finish();
    end
endmodule : smtp_trigger_port_tb
`default_nettype wire
